//--- ambient_light_defs.svh
// offsets, field positions, reset values and timing counts for the light tracker
`ifndef AMBIENT_LIGHT_DEFS_SVH
`define AMBIENT_LIGHT_DEFS_SVH

`define REG_SAMPLE_RESULT 8'h37
`define REG_AVERAGE_RESULT 8'h38

`define CFG_PWM_MODE_BIT 1
`define CFG_AVG_SEL_MSB 5
`define CFG_AVG_SEL_LSB 3

`define RESET_CODE 8'h00
`define FULL_SCALE_CODE 8'hFF
`define FULL_SCALE_MV 2000

`define CLK_PERIOD_PS 4000
`define SAMPLE_PERIOD_NS 140000
`define SAMPLE_CYCLES_CALC ((`SAMPLE_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define FAST_AVG_NS 1100000
`define FAST_AVG_SAMPLES_CALC ((`FAST_AVG_NS + (`SAMPLE_PERIOD_NS / 2)) / `SAMPLE_PERIOD_NS)
`define FAST_PERIODS 2'h3
`define QUAL_PERIODS 2'h3

`define AVG_SAMPLES_0 12'h010
`define AVG_SAMPLES_1 12'h020
`define AVG_SAMPLES_2 12'h040
`define AVG_SAMPLES_3 12'h080
`define AVG_SAMPLES_4 12'h100
`define AVG_SAMPLES_5 12'h200
`define AVG_SAMPLES_6 12'h400
`define AVG_SAMPLES_7 12'h800

`define DIV_STEPS 5'h14

`endif

//--- ambient_light_pkg.sv
// types shared by the light tracker modules
package ambient_light_pkg;

  typedef logic [2:0] zone_t;

  typedef enum logic [1:0] {
    ALGO_DIRECT = 2'b00,
    ALGO_UP_ONLY = 2'b01,
    ALGO_DOWN_DELAY = 2'b10
  } algo_t;

  typedef enum logic [1:0] {
    AVG_RUN = 2'b00,
    AVG_DIVIDE = 2'b01,
    AVG_LATCH = 2'b10
  } avg_state_t;

  typedef struct packed {
    logic [3:0][7:0] upper;
    logic [3:0][7:0] lower;
  } zone_thresh_t;

  typedef struct packed {
    algo_t algo;
    logic [4:0][7:0] target;
  } mapper_cfg_t;

  typedef struct packed {
    logic adcEnable;
    logic convStrobe;
    logic pwmPathEnable;
    logic gainHighZ;
    logic [6:0] gainSelect;
  } afe_ctrl_t;

endpackage : ambient_light_pkg

//--- zone_classifier.sv
// hysteresis zone classifier for an averaged light level
`timescale 1ns/1ps
module zone_classifier (
  input wire logic [7:0] level,
  input wire ambient_light_pkg::zone_t curZone,
  input wire ambient_light_pkg::zone_thresh_t thresh,
  output ambient_light_pkg::zone_t newZone
);
  import ambient_light_pkg::*;

  zone_t z;

  always_comb
  begin
    z = curZone;
    // ascending walk lets a large jump cross several boundaries at once
    for (int k = 0; k < 4; k++)
    begin
      if (z == zone_t'(k) && level > thresh.upper[k])
        z = zone_t'(k + 1);
    end
    for (int k = 3; k >= 0; k--)
    begin
      if (z == zone_t'(k + 1) && level < thresh.lower[k])
        z = zone_t'(k);
    end
    newZone = z;
  end

endmodule : zone_classifier

//--- zone_mapper.sv
// one zone mapper: qualifies averager zone moves and holds the brightness target
`timescale 1ns/1ps
`include "ambient_light_defs.svh"
module zone_mapper (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic periodDone,
  input wire ambient_light_pkg::zone_t zoneOld,
  input wire ambient_light_pkg::zone_t zoneNew,
  input wire ambient_light_pkg::mapper_cfg_t cfg,
  output ambient_light_pkg::zone_t targetZone,
  output logic [7:0] targetCode
);
  import ambient_light_pkg::*;

  logic qualified;
  logic dirUp;
  logic [1:0] count;
  logic next_qualified;
  logic next_dirUp;
  logic [1:0] next_count;
  zone_t next_targetZone;
  logic [7:0] next_targetCode;
  logic moveUp;
  logic moveDown;
  logic mayForce;

  assign moveUp = zoneNew > zoneOld;
  assign moveDown = zoneNew < zoneOld;

  always_comb
  begin
    next_qualified = qualified;
    next_dirUp = dirUp;
    next_count = count;
    next_targetZone = targetZone;
    mayForce = 1'b1;
    if (restart)
    begin
      next_qualified = 1'b0;
      next_dirUp = 1'b0;
      next_count = 2'h0;
      next_targetZone = zone_t'(0);
    end
    else if (periodDone)
    begin
      if (qualified && ((moveUp && dirUp) || (moveDown && !dirUp)))
        next_targetZone = zoneNew;
      else
      begin
        // a stall or reversal after a forced move starts over
        next_qualified = 1'b0;
        next_count = qualified ? 2'h0 : count;
        if (moveUp || moveDown)
        begin
          if (next_count == 2'h0 || moveUp != dirUp)
            next_count = 2'h1;
          else
            next_count = next_count + 2'h1;
          next_dirUp = moveUp;
        end
        else if (next_count != 2'h0)
          next_count = next_count + 2'h1;
        if (next_count == `QUAL_PERIODS)
        begin
          // up-only never lowers; down-delay extra wait is not modelled here
          unique case (cfg.algo)
            ALGO_DIRECT: mayForce = 1'b1;
            ALGO_UP_ONLY: mayForce = next_dirUp && zoneNew > targetZone;
            ALGO_DOWN_DELAY: mayForce = 1'b1;
            default: mayForce = 1'b0;
          endcase
          next_count = 2'h0;
          next_qualified = mayForce;
          if (mayForce)
            next_targetZone = zoneNew;
        end
      end
    end
    next_targetCode = cfg.target[next_targetZone];
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      qualified <= 1'b0;
      dirUp <= 1'b0;
      count <= 2'h0;
      targetZone <= zone_t'(0);
      targetCode <= `RESET_CODE;
    end
    else
    begin
      qualified <= next_qualified;
      dirUp <= next_dirUp;
      count <= next_count;
      targetZone <= next_targetZone;
      targetCode <= next_targetCode;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_target_period_edge: assert property (
    !$stable(targetZone) |-> $past(periodDone) || $past(restart))
    else $error("target moved outside a period boundary");
  chk_target_from_output: assert property (
    !$stable(targetZone) && !$past(restart) |-> targetZone == $past(zoneNew))
    else $error("target is not the averager output zone");
  chk_up_only_rises: assert property (
    cfg.algo == ALGO_UP_ONLY && !restart ##1 !$stable(targetZone) && !$past(restart)
    |-> targetZone > $past(targetZone))
    else $error("up-only mapper lowered its target");
  chk_code_follows_zone: assert property (
    (rstn && $stable(cfg)) [*2] |-> targetCode == cfg.target[targetZone])
    else $error("target code does not match target zone");

  cov_forced_move: cover property (periodDone && !qualified ##1 qualified);
  cov_follow_on: cover property (qualified && periodDone ##1 qualified && !$stable(targetZone));

endmodule : zone_mapper

//--- ambient_light_zone_tracker.sv
// ambient light readout: sampling, averaging, zone tracking and target mapping
`timescale 1ns/1ps
`include "ambient_light_defs.svh"

// How it works
// - config bit 1 set selects PWM sensor path
// - config bit 1 clear selects analog resistor path
// - PWM mode forces gain resistor high impedance
// - 8-bit codes, 0xFF means 2V full scale
// - convert continuously at 7.142ksps while enabled
// - latest sample readable at 0x37, every 140us
// - averager means all samples of each period
// - average readable at 0x38, refreshed each period
// - zone latched into averager output each period
// - five zones from four threshold pairs
// - hysteresis: cross upper to rise, lower to fall
// - sensing start begins in zone zero
// - startup uses fast 1.1ms averaging period
// - three fast periods, then programmed period
// - each mapper picks direct, up-only, down-delay
// - mapper one feeds bank one only
// - upward move needs three qualifying periods
// - downward move needs three qualifying periods
// - same-direction change after forced move follows immediately
// - reversal restarts the qualification; a stall restarts it only after a forced move
// - target changes only at period start
// - forced target is averager output zone's target
// - direct mode moves target both ways
module ambient_light_zone_tracker #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES_CALC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sensingEnable,
  input wire logic [7:0] sensorConfig,
  input wire logic [6:0] resistorSelect,
  input wire ambient_light_pkg::zone_thresh_t zoneThresh,
  input wire ambient_light_pkg::mapper_cfg_t [2:0] mapperCfg,
  input wire logic [4:0][1:0] bankMapperSelect,
  input wire logic [7:0] adcCode,
  input wire logic [7:0] readAddr,
  output ambient_light_pkg::afe_ctrl_t afeCtrl,
  output logic [7:0] readData,
  output logic [5:0][7:0] bankCode,
  output ambient_light_pkg::zone_t averagerZone,
  output logic startupActive
);
  import ambient_light_pkg::*;

  localparam logic [11:0] FAST_SAMPLES = 12'(`FAST_AVG_SAMPLES_CALC);

  logic pwmMode;
  logic [2:0] avgSelect;
  logic [31:0] sampleTimer;
  logic [31:0] next_sampleTimer;
  logic sampleTick;
  logic [7:0] sampleResult;
  logic [7:0] next_sampleResult;

  avg_state_t avgState;
  avg_state_t next_avgState;
  logic [19:0] sum;
  logic [19:0] next_sum;
  logic [11:0] count;
  logic [11:0] next_count;
  logic [11:0] divisor;
  logic [11:0] next_divisor;
  logic [19:0] quot;
  logic [19:0] next_quot;
  logic [12:0] rem;
  logic [12:0] next_rem;
  logic [4:0] step;
  logic [4:0] next_step;
  logic [12:0] trial;
  logic [11:0] periodSamples;
  logic [7:0] averageResult;
  logic [7:0] next_averageResult;
  zone_t next_averagerZone;
  zone_t classZone;
  logic [1:0] fastLeft;
  logic [1:0] next_fastLeft;
  logic periodDone;
  logic [7:0] next_readData;
  logic [5:0][7:0] next_bankCode;
  logic [2:0][7:0] mapperCode;

  assign pwmMode = sensorConfig[`CFG_PWM_MODE_BIT];
  assign avgSelect = sensorConfig[`CFG_AVG_SEL_MSB:`CFG_AVG_SEL_LSB];

  always_comb
  begin
    afeCtrl.adcEnable = sensingEnable;
    afeCtrl.convStrobe = sampleTick;
    afeCtrl.pwmPathEnable = pwmMode;
    afeCtrl.gainHighZ = pwmMode;
    // resistor code passes through only in analog mode
    afeCtrl.gainSelect = pwmMode ? 7'h00 : resistorSelect;
  end

  function automatic logic [11:0] avgSamples(input logic [2:0] sel);
    logic [11:0] n;
    n = `AVG_SAMPLES_0;
    unique case (sel)
      3'h0: n = `AVG_SAMPLES_0;
      3'h1: n = `AVG_SAMPLES_1;
      3'h2: n = `AVG_SAMPLES_2;
      3'h3: n = `AVG_SAMPLES_3;
      3'h4: n = `AVG_SAMPLES_4;
      3'h5: n = `AVG_SAMPLES_5;
      3'h6: n = `AVG_SAMPLES_6;
      3'h7: n = `AVG_SAMPLES_7;
    endcase
    return n;
  endfunction : avgSamples

  // sample pacing
  assign sampleTick = sensingEnable && sampleTimer == 32'(SAMPLE_CYCLES - 1);

  always_comb
  begin
    next_sampleTimer = sampleTimer + 32'h0000_0001;
    next_sampleResult = sampleResult;
    if (!sensingEnable || sampleTick)
      next_sampleTimer = 32'h0000_0000;
    if (sampleTick)
      next_sampleResult = adcCode;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      sampleTimer <= 32'h0000_0000;
      sampleResult <= `RESET_CODE;
    end
    else
    begin
      sampleTimer <= next_sampleTimer;
      sampleResult <= next_sampleResult;
    end
  end

  // averager with a serial divider; the divide ends long before the next sample
  assign periodSamples = (fastLeft != 2'h0) ? FAST_SAMPLES : avgSamples(avgSelect);
  assign trial = {rem[11:0], quot[19]};
  assign periodDone = avgState == AVG_LATCH;

  zone_classifier zone_classifier_inst (
    .level(quot[7:0]),
    .curZone(averagerZone),
    .thresh(zoneThresh),
    .newZone(classZone)
  );

  always_comb
  begin
    next_avgState = avgState;
    next_sum = sum;
    next_count = count;
    next_divisor = divisor;
    next_quot = quot;
    next_rem = rem;
    next_step = step;
    next_averageResult = averageResult;
    next_averagerZone = averagerZone;
    next_fastLeft = fastLeft;
    if (!sensingEnable)
    begin
      next_avgState = AVG_RUN;
      next_sum = 20'h0_0000;
      next_count = 12'h000;
      next_averagerZone = zone_t'(0);
      next_fastLeft = `FAST_PERIODS;
    end
    else
    begin
      unique case (avgState)
        AVG_RUN:
        begin
          if (sampleTick)
          begin
            next_sum = sum + 20'(adcCode);
            next_count = count + 12'h001;
            if (next_count >= periodSamples)
            begin
              next_avgState = AVG_DIVIDE;
              next_quot = next_sum;
              next_divisor = next_count;
              next_rem = 13'h0000;
              next_step = `DIV_STEPS;
              next_sum = 20'h0_0000;
              next_count = 12'h000;
            end
          end
        end
        AVG_DIVIDE:
        begin
          if (trial >= {1'b0, divisor})
          begin
            next_rem = trial - {1'b0, divisor};
            next_quot = {quot[18:0], 1'b1};
          end
          else
          begin
            next_rem = trial;
            next_quot = {quot[18:0], 1'b0};
          end
          next_step = step - 5'h01;
          if (step == 5'h01)
            next_avgState = AVG_LATCH;
        end
        AVG_LATCH:
        begin
          next_averageResult = quot[7:0];
          next_averagerZone = classZone;
          if (fastLeft != 2'h0)
            next_fastLeft = fastLeft - 2'h1;
          next_avgState = AVG_RUN;
        end
        default: next_avgState = AVG_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      avgState <= AVG_RUN;
      sum <= 20'h0_0000;
      count <= 12'h000;
      divisor <= 12'h001;
      quot <= 20'h0_0000;
      rem <= 13'h0000;
      step <= 5'h00;
      averageResult <= `RESET_CODE;
      averagerZone <= zone_t'(0);
      fastLeft <= `FAST_PERIODS;
    end
    else
    begin
      avgState <= next_avgState;
      sum <= next_sum;
      count <= next_count;
      divisor <= next_divisor;
      quot <= next_quot;
      rem <= next_rem;
      step <= next_step;
      averageResult <= next_averageResult;
      averagerZone <= next_averagerZone;
      fastLeft <= next_fastLeft;
    end
  end

  assign startupActive = sensingEnable && fastLeft != 2'h0;

  // mappers and bank routing
  for (genvar m = 0; m < 3; m++)
  begin : gMapper
    zone_mapper zone_mapper_inst (
      .mclk(mclk),
      .rstn(rstn),
      .restart(!sensingEnable),
      .periodDone(periodDone),
      .zoneOld(averagerZone),
      .zoneNew(classZone),
      .cfg(mapperCfg[m]),
      .targetZone(),
      .targetCode(mapperCode[m])
    );
  end

  always_comb
  begin
    next_bankCode[0] = mapperCode[0];
    for (int b = 1; b < 6; b++)
    begin
      unique case (bankMapperSelect[b - 1])
        2'h1: next_bankCode[b] = mapperCode[1];
        2'h2: next_bankCode[b] = mapperCode[2];
        default: next_bankCode[b] = `RESET_CODE;
      endcase
    end
    unique case (readAddr)
      `REG_SAMPLE_RESULT: next_readData = sampleResult;
      `REG_AVERAGE_RESULT: next_readData = averageResult;
      default: next_readData = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bankCode <= '0;
      readData <= 8'h00;
    end
    else
    begin
      bankCode <= next_bankCode;
      readData <= next_readData;
    end
  end

  // checking
  logic [31:0] gapCount;
  always_ff @(posedge mclk)
  begin
    if (!rstn || !sensingEnable || sampleTick)
      gapCount <= 32'h0000_0000;
    else
      gapCount <= gapCount + 32'h0000_0001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_sample_spacing: assert property (
    sampleTick |-> gapCount == 32'(SAMPLE_CYCLES - 1))
    else $error("samples not evenly spaced");
  chk_sample_capture: assert property (
    sampleTick |=> sampleResult == $past(adcCode))
    else $error("sample register did not capture converter code");
  chk_sample_read: assert property (
    readAddr == `REG_SAMPLE_RESULT |=> readData == $past(sampleResult))
    else $error("sample register read back wrong value");
  chk_highz_pwm: assert property (
    pwmMode |-> afeCtrl.gainHighZ && afeCtrl.gainSelect == 7'h00)
    else $error("gain resistor not high impedance in pwm mode");
  chk_avg_update: assert property (
    !$stable(averageResult) |-> $past(periodDone) && averageResult == $past(quot[7:0]))
    else $error("average changed outside a period end");
  chk_zone_update: assert property (
    !$stable(averagerZone) |-> $past(periodDone) || !$past(sensingEnable))
    else $error("averager zone changed mid-period");
  chk_zone_reset: assert property (
    !sensingEnable |=> averagerZone == 3'h0 && fastLeft == `FAST_PERIODS)
    else $error("disabled tracker did not return to zone zero");
  chk_fast_count: assert property (
    periodDone && fastLeft != 2'h0 && sensingEnable |=> fastLeft == $past(fastLeft) - 2'h1)
    else $error("fast period count did not advance");
  chk_zone_hyst: assert property (
    periodDone && classZone > averagerZone |-> quot[7:0] > zoneThresh.upper[classZone - 3'h1])
    else $error("zone rose without crossing upper threshold");
  chk_period_len: assert property (
    sampleTick && avgState == AVG_RUN && count + 12'h001 == periodSamples |=> avgState == AVG_DIVIDE)
    else $error("averaging period length not honoured");

  cov_startup_done: cover property (startupActive ##1 !startupActive && sensingEnable);
  cov_zone_rise: cover property (periodDone && classZone > averagerZone);
  cov_zone_fall: cover property (periodDone && classZone < averagerZone);

endmodule : ambient_light_zone_tracker

//--- ambient_light_sensor_model.sv
// behavioural light sensor and converter front end
`timescale 1ns/1ps
module ambient_light_sensor_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire ambient_light_pkg::afe_ctrl_t afeCtrl,
  input wire logic [7:0] level,
  output logic [7:0] adcCode
);
  import ambient_light_pkg::*;
  logic phase;
  logic next_phase;
  logic [7:0] noise;
  logic [7:0] next_noise;

  // samples alternate level and level+2, so an even period averages to level+1
  always_comb
  begin
    next_phase = phase;
    next_noise = noise + 8'h5B;
    if (!afeCtrl.adcEnable)
      next_phase = 1'b0;
    else if (afeCtrl.convStrobe)
      next_phase = ~phase;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      phase <= 1'b0;
      noise <= 8'h00;
    end
    else
    begin
      phase <= next_phase;
      noise <= next_noise;
    end
  end

  // junk outside the strobe so an early or late capture shows
  assign adcCode = afeCtrl.convStrobe ? (level + (phase ? 8'h02 : 8'h00)) : noise;
endmodule : ambient_light_sensor_model

//--- test_ambient_light_zone_tracker.sv
// self-checking bench for the light zone tracker
`timescale 1ns/1ps
`include "ambient_light_defs.svh"
module test_ambient_light_zone_tracker;
  import ambient_light_pkg::*;
  localparam int SC = 40;
  localparam logic [7:0] LV [0:10] = '{8'h70, 8'h70, 8'h70, 8'hA0, 8'h40, 8'h40, 8'h40,
    8'h40, 8'h70, 8'h54, 8'h54};
  localparam logic [7:0] ZN [0:10] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01,
    8'h01, 8'h02, 8'h02, 8'h02};
  localparam logic [7:0] T1 [0:10] = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h03, 8'h03, 8'h01,
    8'h01, 8'h01, 8'h01, 8'h02};
  localparam logic [7:0] T3 [0:10] = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
    8'h03, 8'h03, 8'h03};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic sensingEnable = 1'b0;
  logic [7:0] sensorConfig = 8'h00;
  logic [6:0] resistorSelect = 7'h00;
  zone_thresh_t zoneThresh;
  mapper_cfg_t [2:0] mapperCfg;
  logic [4:0][1:0] bankMapperSelect = 10'h009;
  logic [7:0] adcCode;
  logic [7:0] readAddr = 8'h00;
  logic [7:0] level = 8'h00;
  afe_ctrl_t afeCtrl;
  logic [7:0] readData;
  logic [5:0][7:0] bankCode;
  zone_t averagerZone;
  logic startupActive;
  int errCount = 0;
  int checked = 0;

  always #2 mclk = ~mclk;

  ambient_light_zone_tracker #(.SAMPLE_CYCLES(SC)) ambient_light_zone_tracker_inst (
    .mclk(mclk), .rstn(rstn), .sensingEnable(sensingEnable), .sensorConfig(sensorConfig),
    .resistorSelect(resistorSelect), .zoneThresh(zoneThresh), .mapperCfg(mapperCfg),
    .bankMapperSelect(bankMapperSelect), .adcCode(adcCode), .readAddr(readAddr),
    .afeCtrl(afeCtrl), .readData(readData), .bankCode(bankCode),
    .averagerZone(averagerZone), .startupActive(startupActive));

  ambient_light_sensor_model ambient_light_sensor_model_inst (
    .mclk(mclk), .rstn(rstn), .afeCtrl(afeCtrl), .level(level), .adcCode(adcCode));

  task automatic tally_and_finish;
    $display("counts: checked=%0d mismatches=%0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] t=%0t %s got 0x%h exp 0x%h", $time, what, got, exp);
    end
  endtask : check8

  // bounded so a dead converter cannot hang the run
  task automatic wait_strobes(input int n);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    while (seen < n && guard < n * SC * 2)
    begin
      @(posedge mclk);
      #1;
      guard++;
      if (afeCtrl.convStrobe === 1'b1)
        seen++;
    end
    check8(8'(seen), 8'(n), "strobe count");
  endtask : wait_strobes

  // returns well after latch and bank update, before the next strobe
  task automatic period(input logic [7:0] lv, input int n, input logic [7:0] hold);
    @(posedge mclk);
    level <= lv;
    wait_strobes(n - 1);
    check8(bankCode[0], hold, "bank mid period");
    wait_strobes(1);
    repeat (25) @(posedge mclk);
    #1;
  endtask : period

  task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
    @(posedge mclk);
    readAddr <= addr;
    @(posedge mclk);
    @(posedge mclk);
    #1;
    check8(readData, exp, what);
  endtask : read_reg

  task automatic set_enable(input logic en);
    @(posedge mclk);
    sensingEnable <= en;
    @(posedge mclk);
    #1;
  endtask : set_enable

  task automatic t_afe;
    int bad;
    bad = 0;
    @(posedge mclk);
    sensorConfig <= 8'h02;
    resistorSelect <= 7'h55;
    @(posedge mclk);
    #1;
    check8({7'h0, afeCtrl.pwmPathEnable}, 8'h01, "pwm path");
    check8({7'h0, afeCtrl.gainHighZ}, 8'h01, "gain high-z");
    check8({1'b0, afeCtrl.gainSelect}, 8'h00, "gain select");
    @(posedge mclk);
    sensorConfig <= 8'h00;
    @(posedge mclk);
    #1;
    check8({7'h0, afeCtrl.pwmPathEnable}, 8'h00, "pwm path");
    check8({7'h0, afeCtrl.gainHighZ}, 8'h00, "gain high-z");
    check8({1'b0, afeCtrl.gainSelect}, 8'h55, "gain select");
    repeat (2 * SC)
    begin
      @(posedge mclk);
      #1;
      if (afeCtrl.convStrobe !== 1'b0 || afeCtrl.adcEnable !== 1'b0)
        bad++;
    end
    check8(8'(bad), 8'h00, "converter idle");
    $display("test afe done");
  endtask : t_afe

  task automatic t_sample;
    longint t0;
    @(posedge mclk);
    level <= 8'hFD;
    set_enable(1'b1);
    check8({7'h0, afeCtrl.adcEnable}, 8'h01, "converter enable");
    wait_strobes(1);
    t0 = $time;
    read_reg(`REG_SAMPLE_RESULT, 8'hFD, "first sample");
    wait_strobes(1);
    check8(8'(($time - t0) / 4), 8'(SC), "sample spacing");
    read_reg(`REG_SAMPLE_RESULT, 8'hFF, "full scale sample");
    read_reg(8'h36, 8'h00, "unmapped read");
    set_enable(1'b0);
    read_reg(`REG_SAMPLE_RESULT, 8'hFF, "sample kept");
    $display("test sample done");
  endtask : t_sample

  task automatic t_startup;
    @(posedge mclk);
    level <= 8'hA0;
    mapperCfg[2].algo <= ALGO_DOWN_DELAY;
    set_enable(1'b1);
    check8({5'h0, averagerZone}, 8'h00, "initial zone");
    check8({7'h0, startupActive}, 8'h01, "startup flag");
    period(8'hA0, 8, 8'h10);
    check8({5'h0, averagerZone}, 8'h03, "zone after fast period");
    read_reg(`REG_AVERAGE_RESULT, 8'hA1, "average");
    check8(bankCode[0], 8'h10, "no force yet");
    period(8'hA0, 8, 8'h10);
    check8({7'h0, startupActive}, 8'h01, "startup flag");
    period(8'hA0, 8, 8'h10);
    check8({7'h0, startupActive}, 8'h00, "startup over");
    check8(bankCode[0], 8'h13, "forced after three");
    check8(bankCode[2], 8'h33, "delay mapper rise");
    set_enable(1'b0);
    repeat (3) @(posedge mclk);
    #1;
    check8({5'h0, averagerZone}, 8'h00, "zone cleared");
    check8(bankCode[0], 8'h10, "target cleared");
    read_reg(`REG_AVERAGE_RESULT, 8'hA1, "average kept");
    $display("test startup done");
  endtask : t_startup

  task automatic t_direct;
    logic [7:0] hold;
    @(posedge mclk);
    mapperCfg[2].algo <= ALGO_UP_ONLY;
    level <= 8'h10;
    set_enable(1'b1);
    repeat (3) period(8'h10, 8, 8'h10);
    hold = 8'h10;
    for (int i = 0; i < 11; i++)
    begin
      period(LV[i], 16, hold);
      hold = 8'h10 + T1[i];
      check8({5'h0, averagerZone}, ZN[i], "averager zone");
      check8(bankCode[0], hold, "bank one target");
      check8(bankCode[1], 8'h20 + T1[i], "mapper two bank");
      check8(bankCode[2], 8'h30 + T3[i], "up-only bank");
      check8(bankCode[3], 8'h00, "unassigned bank");
    end
    read_reg(`REG_AVERAGE_RESULT, 8'h55, "last average");
    $display("test direct done");
  endtask : t_direct

  initial
  begin
    zoneThresh.upper = 32'hC090_6030;
    zoneThresh.lower = 32'hB080_5020;
    mapperCfg[0].algo = ALGO_DIRECT;
    mapperCfg[0].target = 40'h14_1312_1110;
    mapperCfg[1].algo = ALGO_DIRECT;
    mapperCfg[1].target = 40'h24_2322_2120;
    mapperCfg[2].algo = ALGO_UP_ONLY;
    mapperCfg[2].target = 40'h34_3332_3130;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    read_reg(`REG_AVERAGE_RESULT, 8'h00, "average after reset");
    t_afe;
    t_sample;
    t_startup;
    t_direct;
    tally_and_finish;
  end

  // the whole sequence needs about 9200 cycles
  initial
  begin
    repeat (40000) @(posedge mclk);
    errCount++;
    $display("[ERR] t=%0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule : test_ambient_light_zone_tracker
